//--- logic/rtsq_pkg.sv
package rtsq_pkg;

   // ==========================================================
   // Register map (index; byte address is four times the index)
   // ==========================================================
   localparam logic [7:0] CTL_ONE_IDX  = 8'h36;
   localparam logic [7:0] CTL_TWO_IDX  = 8'h37;
   localparam logic [7:0] STATUS_IDX   = 8'h50;
   localparam logic [7:0] CTL_ONE_RST  = 8'h00;
   localparam logic [7:0] CTL_TWO_RST  = 8'h00;
   localparam int         ADDR_W       = 10;

   // ==========================================================
   // Field positions, control one
   // ==========================================================
   localparam int GO_BIT          = 7;
   localparam int HALT_BIT        = 6;
   localparam int LP_MODE_BIT     = 5;
   localparam int FROM_IDLE_HI    = 4;
   localparam int FROM_IDLE_LO    = 3;
   localparam int EOA_TARGET_BIT  = 2;
   localparam int FROM_LP_BIT     = 1;
   localparam int FROM_TX_BIT     = 0;

   // ==========================================================
   // Field positions, control two
   // ==========================================================
   localparam int FROM_RX_HI      = 7;
   localparam int FROM_RX_LO      = 5;
   localparam int DEADLINE_HI     = 4;
   localparam int DEADLINE_LO     = 3;
   localparam int FROM_PKT_HI     = 2;
   localparam int FROM_PKT_LO     = 0;

   // ==========================================================
   // Sequencer states and chip mode requests
   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOWPWR,
      ST_RX,
      ST_TX,
      ST_PKT_RCVD,
      ST_RX_RESTART,
      ST_WAIT_QUEUE,
      ST_SYNTH
   } rtsq_state_e;

   typedef enum logic [2:0] {
      MODE_NONE,
      MODE_STANDBY,
      MODE_SLEEP,
      MODE_SYNTH_ONLY,
      MODE_RX,
      MODE_TX
   } rtsq_mode_e;

endpackage : rtsq_pkg

//--- logic/rtsq_top.sv
// Added by the designer: register access over Avalon-MM.
module rtsq_top
   import rtsq_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire logic [ADDR_W-1:0]    avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic                 chip_in_sleep_or_stby,
   input  wire logic                 crc_enabled,
   input  wire logic                 freq_changed,
   input  wire logic                 wake_timer_event,
   input  wire logic                 rx_window_timer_event,
   input  wire logic                 payload_ready_event,
   input  wire logic                 check_pass_event,
   input  wire logic                 frame_sent_event,
   input  wire logic                 sync_match_event,
   input  wire logic                 preamble_seen_event,
   input  wire logic                 signal_level_event,
   input  wire logic                 rx_deadline_event,
   input  wire logic                 queue_empty_flag,
   input  wire logic                 synth_ready_event,
   output rtsq_state_e               seq_state,
   output rtsq_mode_e                chip_mode_req,
   output logic                      rx_restart_pulse
);
   import rtsq_pkg::*;

   // ==========================================================
   // Bus slave
   // ==========================================================
   // One wait cycle per access: the first edge latches read data and
   // drops waitrequest, the next edge completes the transfer.
   logic                wait_r;
   logic [31:0]         rdata_r;
   logic [7:0]          ctl1_r;
   logic [7:0]          ctl2_r;
   rtsq_state_e         state_r;
   rtsq_state_e         state_nxt;
   rtsq_mode_e          mode_r;
   rtsq_mode_e          mode_nxt;
   logic                restart_r;

   wire        req       = avs_read | avs_write;
   wire        addr_ok   = (avs_address[1:0] == 2'h0);
   wire [7:0]  idx       = avs_address[ADDR_W-1:2];
   wire        sel1      = addr_ok && (idx == CTL_ONE_IDX);
   wire        sel2      = addr_ok && (idx == CTL_TWO_IDX);
   wire        sels      = addr_ok && (idx == STATUS_IDX);
   wire        wr_done   = avs_write && !wait_r && avs_byteenable[0];
   wire        wr1       = wr_done && sel1;
   wire        wr2       = wr_done && sel2;
   wire        go_cmd    = wr1 && avs_writedata[GO_BIT];
   wire        halt_cmd  = wr1 && avs_writedata[HALT_BIT];
   // Settings written together with go must steer that very start, so the
   // decode sees the incoming byte in the write cycle
   wire [7:0]  ctl1_eff  = wr1 ? {2'h0, avs_writedata[LP_MODE_BIT:0]} : ctl1_r;

   // Trigger bits are never stored, so they read as zero
   wire [7:0]  ctl1_rd   = {2'h0, ctl1_r[LP_MODE_BIT:0]};
   wire [7:0]  stat_rd   = {2'h0, mode_r, state_r};
   wire [7:0]  rd_byte   = sel1 ? ctl1_rd :
                           sel2 ? ctl2_r :
                           sels ? stat_rd : 8'h00;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0;
      end else begin
         wait_r  <= !(req && wait_r);
         rdata_r <= {24'h0, rd_byte};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctl1_r <= CTL_ONE_RST;
         ctl2_r <= CTL_TWO_RST;
      end else begin
         ctl1_r <= ctl1_eff;
         if (wr2) begin
            ctl2_r <= avs_writedata[7:0];
         end
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata    = rdata_r;

   // ==========================================================
   // Field decode
   // ==========================================================
   wire        lp_sleep   = ctl1_eff[LP_MODE_BIT];
   wire [1:0]  from_idle  = ctl1_eff[FROM_IDLE_HI:FROM_IDLE_LO];
   wire        from_lp    = ctl1_eff[FROM_LP_BIT];
   wire        from_tx    = ctl1_eff[FROM_TX_BIT];
   wire [2:0]  from_rx    = ctl2_r[FROM_RX_HI:FROM_RX_LO];
   wire [1:0]  on_dead    = ctl2_r[DEADLINE_HI:DEADLINE_LO];
   wire [2:0]  from_pkt   = ctl2_r[FROM_PKT_HI:FROM_PKT_LO];

   // Resting state after any action
   wire rtsq_state_e rest_st = ctl1_eff[EOA_TARGET_BIT] ? ST_IDLE : ST_LOWPWR;

   // Deadline mapping, shared with payload ready under code 011
   rtsq_state_e dead_st;
   always_comb begin
      unique case (on_dead)
         2'h0:    dead_st = ST_RX_RESTART;
         2'h1:    dead_st = ST_TX;
         2'h2:    dead_st = rest_st;
         default: dead_st = ST_IDLE;
      endcase
   end

   // Code-selected exit from Receive; stays put when nothing fires
   rtsq_state_e rx_code_st;
   always_comb begin
      rx_code_st = ST_RX;
      unique case (from_rx)
         3'h1: if (payload_ready_event) rx_code_st = ST_PKT_RCVD;
         3'h2: if (payload_ready_event) rx_code_st = rest_st;
         3'h3: begin
            if (check_pass_event) begin
               rx_code_st = ST_PKT_RCVD;
            end else if (payload_ready_event) begin
               rx_code_st = crc_enabled ? dead_st : ST_PKT_RCVD;
            end
         end
         3'h4: if (signal_level_event)  rx_code_st = ST_IDLE;
         3'h5: if (sync_match_event)    rx_code_st = ST_IDLE;
         3'h6: if (preamble_seen_event) rx_code_st = ST_IDLE;
         default: rx_code_st = ST_RX;
      endcase
   end

   // Exit from packet-received
   rtsq_state_e pkt_st;
   always_comb begin
      pkt_st = ST_PKT_RCVD;
      unique case (from_pkt)
         3'h0: pkt_st = ST_IDLE;
         3'h1: if (queue_empty_flag) pkt_st = ST_TX;
         3'h2: if (queue_empty_flag) pkt_st = rest_st;
         3'h3: pkt_st = freq_changed ? ST_SYNTH : ST_RX;
         3'h4: pkt_st = ST_RX;
         // Codes above 100 have no exit and park until halted
         default: pkt_st = ST_PKT_RCVD;
      endcase
   end

   // Start transition target
   rtsq_state_e idle_st;
   always_comb begin
      unique case (from_idle)
         2'h0:    idle_st = rest_st;
         2'h1:    idle_st = ST_RX;
         2'h2:    idle_st = ST_TX;
         default: idle_st = ST_WAIT_QUEUE;
      endcase
   end

   // ==========================================================
   // State machine
   // ==========================================================
   // All events are taken as one-cycle pulses on ref_clk
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (go_cmd && chip_in_sleep_or_stby) begin
               state_nxt = idle_st;
            end
         end
         ST_LOWPWR: begin
            if (wake_timer_event) begin
               state_nxt = from_lp ? ST_TX : ST_RX;
            end
         end
         ST_TX: begin
            if (frame_sent_event) begin
               state_nxt = from_tx ? rest_st : ST_RX;
            end
         end
         ST_RX: begin
            if (rx_window_timer_event) begin
               state_nxt = rest_st;
            end else if (rx_deadline_event) begin
               state_nxt = dead_st;
            end else begin
               state_nxt = rx_code_st;
            end
         end
         ST_PKT_RCVD:   state_nxt = pkt_st;
         // Restart lasts one cycle, then reception starts afresh
         ST_RX_RESTART: state_nxt = ST_RX;
         // Transmit starts once the queue holds at least one byte
         ST_WAIT_QUEUE: if (!queue_empty_flag) state_nxt = ST_TX;
         ST_SYNTH:      if (synth_ready_event) state_nxt = ST_RX;
      endcase
      if (halt_cmd) begin
         state_nxt = ST_IDLE;
      end
   end

   // Chip mode wanted in each state; Idle leaves the mode to software
   always_comb begin
      unique case (state_nxt)
         ST_LOWPWR:     mode_nxt = lp_sleep ? MODE_SLEEP : MODE_STANDBY;
         ST_RX:         mode_nxt = MODE_RX;
         ST_RX_RESTART: mode_nxt = MODE_RX;
         ST_PKT_RCVD:   mode_nxt = MODE_STANDBY;
         ST_TX:         mode_nxt = MODE_TX;
         ST_WAIT_QUEUE: mode_nxt = MODE_STANDBY;
         ST_SYNTH:      mode_nxt = MODE_SYNTH_ONLY;
         default:       mode_nxt = MODE_NONE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r   <= ST_IDLE;
         mode_r    <= MODE_NONE;
         restart_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         mode_r    <= mode_nxt;
         restart_r <= (state_nxt == ST_RX_RESTART);
      end
   end

   assign seq_state        = state_r;
   assign chip_mode_req    = mode_r;
   assign rx_restart_pulse = restart_r;

endmodule : rtsq_top

//--- verification/rtsq_top_sva.sv
module rtsq_sva
   import rtsq_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_writedata,
   input wire logic [3:0]        avs_byteenable,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              chip_in_sleep_or_stby,
   input wire logic              wake_timer_event,
   input wire logic              rx_window_timer_event,
   input wire logic              frame_sent_event,
   input wire rtsq_state_e       seq_state,
   input wire rtsq_mode_e        chip_mode_req,
   input wire logic              rx_restart_pulse
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // Bus access qualifiers
   // ==========================================================
   wire acc_w   = avs_write && !avs_waitrequest;
   wire ctl_one = avs_address == 10'h0d8;
   wire halt_w  = acc_w && ctl_one && avs_byteenable[0] && avs_writedata[6];
   sequence window_s;
      seq_state == ST_RX && rx_window_timer_event && !acc_w;
   endsequence
   sequence restart_s;
      rx_restart_pulse ##1 seq_state == ST_RX;
   endsequence
   // ==========================================================
   // Properties
   // ==========================================================
   wait_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   halt_idle_a: assert property (halt_w |=> seq_state == ST_IDLE)
      else $error("halt write did not force idle");
   halt_read_a: assert property (avs_read && !avs_waitrequest && ctl_one |-> avs_readdata[7:6] == 2'b00)
      else $error("trigger bits read back nonzero");
   idle_hold_a: assert property (seq_state == ST_IDLE && !acc_w |=> seq_state == ST_IDLE)
      else $error("left idle without a command");
   go_block_a: assert property (seq_state == ST_IDLE && !chip_in_sleep_or_stby |=> seq_state == ST_IDLE)
      else $error("go honoured outside sleep or standby");
   lp_mode_a: assert property (seq_state == ST_LOWPWR |-> chip_mode_req inside {MODE_STANDBY, MODE_SLEEP})
      else $error("low power state with wrong chip mode");
   wake_exit_a: assert property (seq_state == ST_LOWPWR && wake_timer_event && !acc_w |=> seq_state inside {ST_RX, ST_TX})
      else $error("wake event did not leave low power");
   sent_exit_a: assert property (seq_state == ST_TX && frame_sent_event && !acc_w |=> seq_state inside {ST_RX, ST_LOWPWR, ST_IDLE})
      else $error("frame sent did not leave transmit");
   window_exit_a: assert property (window_s |=> seq_state inside {ST_LOWPWR, ST_IDLE})
      else $error("receive window event did not end receive");
   restart_back_a: assert property (seq_state == ST_RX_RESTART && !acc_w |-> restart_s)
      else $error("restart not a single pulse back to receive");
endmodule : rtsq_sva

//--- verification/testbench.sv
module testbench
   import rtsq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic [31:0]       avs_writedata = '0, avs_readdata;
   logic [3:0]        avs_byteenable = 4'h1;
   logic              avs_waitrequest, rx_restart_pulse;
   logic              sleep_ok = 1'b1, crc_on = 1'b1, freq_chg = 1'b0, q_empty = 1'b1;
   logic [9:0]        ev = '0;
   rtsq_state_e       seq_state;
   rtsq_mode_e        chip_mode_req;
   logic [7:0]        rd_v, c1, c2;
   int                fail_count = 0, checks = 0;
   int                evt [7] = '{0, 2, 2, 3, 7, 5, 6};
   always #10 ref_clk = ~ref_clk;
   rtsq_top rtsq_top_i (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .chip_in_sleep_or_stby(sleep_ok),
      .crc_enabled(crc_on), .freq_changed(freq_chg), .wake_timer_event(ev[0]),
      .rx_window_timer_event(ev[1]), .payload_ready_event(ev[2]), .check_pass_event(ev[3]),
      .frame_sent_event(ev[4]), .sync_match_event(ev[5]), .preamble_seen_event(ev[6]),
      .signal_level_event(ev[7]), .rx_deadline_event(ev[8]), .queue_empty_flag(q_empty),
      .synth_ready_event(ev[9]), .seq_state, .chip_mode_req, .rx_restart_pulse);
   // ==========================================================
   // Tasks and expectations
   // ==========================================================
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Slave latency is not assumed: the loop waits for waitrequest low
   task automatic bus(bit w, logic [7:0] idx, logic [7:0] d);
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= !w;
      // A slave that never answers is ended by the watchdog
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rd_v = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      #1;
   endtask : bus
   task automatic fire(int i);
      @(posedge ref_clk);
      ev[i] <= 1'b1;
      @(posedge ref_clk);
      ev <= '0;
      #1;
   endtask : fire
   function automatic rtsq_state_e rest(logic eoa);
      return eoa ? ST_IDLE : ST_LOWPWR;
   endfunction : rest
   function automatic rtsq_state_e dl(logic [1:0] s, logic eoa);
      case (s)
         2'b00: return ST_RX_RESTART;
         2'b01: return ST_TX;
         2'b10: return rest(eoa);
         default: return ST_IDLE;
      endcase
   endfunction : dl
   function automatic rtsq_state_e rx_exp(int k, logic [7:0] c, logic eoa);
      if (k >= 12 || k == 7) return dl(c[4:3], eoa);
      if (k >= 8) return rest(eoa);
      case (c[7:5])
         3'd1, 3'd3: return ST_PKT_RCVD;
         3'd2: return rest(eoa);
         default: return ST_IDLE;
      endcase
   endfunction : rx_exp
   task automatic stop_test();
      $display("checks %0d failures %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      void'($urandom(32'he9ef));
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      bus(0, 8'h36, 0); check("ctl_one_rst", rd_v, CTL_ONE_RST);
      bus(0, 8'h37, 0); check("ctl_two_rst", rd_v, CTL_TWO_RST);
      bus(1, 8'h10, 8'hff); bus(0, 8'h10, 0); check("unmapped", rd_v, 8'h00);
      for (int k = 0; k < 8; k++) begin
         c1 = 8'($urandom) & 8'h23 | 8'({k[1:0], k[2], 2'b00});
         bus(1, 8'h36, c1 | 8'h80);
         check("from_idle", seq_state, k[1:0] == 0 ? rest(k[2]) : k[1:0] == 1 ? ST_RX
               : k[1:0] == 2 ? ST_TX : ST_WAIT_QUEUE);
         bus(0, 8'h36, 0); check("go_reads_zero", rd_v, c1);
         if (k == 0) begin
            check("lp_mode", chip_mode_req, c1[5] ? MODE_SLEEP : MODE_STANDBY);
            fire(0); check("from_lp", seq_state, c1[1] ? ST_TX : ST_RX);
         end
         if (k[1:0] == 2) begin
            fire(4); check("from_tx", seq_state, c1[0] ? rest(k[2]) : ST_RX);
         end
         bus(1, 8'h36, 8'h40); check("halt", seq_state, ST_IDLE);
      end
      // Queue kept non-empty so packet-received exits stay visible
      q_empty <= 1'b0;
      for (int k = 0; k < 16; k++) begin
         c2 = 8'($urandom) & 8'h18 | 8'h04;
         c2[7:5] = k < 6 ? 3'(k + 1) : k < 8 ? 3'd3 : 3'(1 + $urandom % 6);
         // Deadline runs walk every mapping once, restart included
         if (k >= 12) c2[4:3] = 2'(k - 12);
         crc_on <= k != 6;
         c1 = 8'($urandom) & 8'h04 | 8'h08;
         bus(1, 8'h37, c2);
         bus(1, 8'h36, c1 | 8'h80);
         fire(k < 6 ? evt[k + 1] : k < 8 ? 2 : k < 12 ? 1 : 8);
         check("from_rx", seq_state, rx_exp(k, c2, c1[2]));
         if (rx_exp(k, c2, c1[2]) == ST_RX_RESTART) begin
            @(posedge ref_clk); #1; check("restart", seq_state, ST_RX);
         end
         bus(1, 8'h36, 8'h40);
      end
      freq_chg <= 1'b1;
      for (int p = 0; p < 5; p++) begin
         c1 = 8'($urandom) & 8'h04 | 8'h08;
         bus(1, 8'h37, 8'(32 + p));
         bus(1, 8'h36, c1 | 8'h80);
         fire(2); check("pkt_in", seq_state, ST_PKT_RCVD);
         q_empty <= 1'b1;
         @(posedge ref_clk); #1;
         check("from_pkt", seq_state, p == 0 ? ST_IDLE : p == 1 ? ST_TX : p == 2 ? rest(c1[2])
               : p == 3 ? ST_SYNTH : ST_RX);
         if (p == 3) begin
            check("synth_mode", chip_mode_req, MODE_SYNTH_ONLY);
            fire(9); check("synth_back", seq_state, ST_RX);
         end
         q_empty <= 1'b0;
         bus(1, 8'h36, 8'h40);
      end
      sleep_ok <= 1'b0;
      bus(1, 8'h36, 8'h88); check("go_blocked", seq_state, ST_IDLE);
      sleep_ok <= 1'b1;
      bus(1, 8'h36, 8'hc8); check("go_and_halt", seq_state, ST_IDLE);
      bus(1, 8'h36, 8'h90); bus(0, 8'h50, 0); check("status", rd_v[2:0], ST_TX);
      check("status_mode", rd_v[5:3], MODE_TX);
      stop_test();
   end
   initial begin
      #200us;
      fail_count++;
      stop_test();
   end
endmodule : testbench
bind rtsq_top rtsq_sva rtsq_sva_i (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .chip_in_sleep_or_stby,
   .wake_timer_event, .rx_window_timer_event, .frame_sent_event, .seq_state, .chip_mode_req,
   .rx_restart_pulse);
